// ===== qcd_pkg.sv
package qcd_pkg;

	// register byte offsets on the 32-bit bus
	localparam logic [7:0] OFS_DIV   = 8'h14; // serial_clock_divider
	localparam logic [7:0] OFS_TXTHR = 8'h18; // tx_fifo_threshold
	localparam logic [7:0] OFS_RXTHR = 8'h1C; // rx_fifo_threshold
	localparam logic [7:0] OFS_TXLVL = 8'h20; // tx_fifo_fill_count
	localparam logic [7:0] OFS_CTRL  = 8'h40; // mode control
	localparam logic [7:0] OFS_STS   = 8'h44; // sticky event status, write one to clear
	localparam logic [7:0] OFS_MASK  = 8'h48; // event enables

	// field layout
	localparam int unsigned DIV_W     = 16; // divider_field width, bits 15:0
	localparam int unsigned THR_W     = 3;  // threshold and level field width
	localparam int unsigned THR_LSB   = 0;  // tx_empty_threshold / rx_full_threshold
	localparam int unsigned START_LSB = 16; // tx_start_level, bits 18:16
	localparam int unsigned CTRL_MST  = 0;  // master mode bit
	localparam int unsigned EV_W      = 2;  // number of event bits
	localparam int unsigned EV_TXE    = 0;  // tx fifo at or below threshold
	localparam int unsigned EV_RXF    = 1;  // rx fifo above threshold

	// reset values
	localparam logic [DIV_W-1:0] DIV_RST  = 16'h0000;
	localparam logic [THR_W-1:0] THR_RST  = 3'h0;
	localparam logic [EV_W-1:0]  MASK_RST = 2'h0;

	// fifo and bus sizing
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned ADDR_W     = 8;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// write channel sequencing
	typedef enum logic [0:0] {
		WS_COLLECT = 1'b0,
		WS_RESP    = 1'b1
	} qcd_wstate_t;

endpackage

// ===== qcd_sclk_div.sv
`timescale 1ns/1ps
module qcd_sclk_div import qcd_pkg::*; #(
	parameter int unsigned DW = DIV_W
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic [DW-1:0] divisor,
	output logic               sclk_q
);
	// counter runs over half the divisor, so its width drops one bit
	typedef struct packed {
		logic [DW-2:0] cnt; // cycles since last edge
		logic          sclk; // serial clock level
	} qcd_div_st_t;

	qcd_div_st_t s_q;
	qcd_div_st_t s_d;
	logic [DW-2:0] half; // block cycles per half period

	if (DW < 2) begin : g_chk
		$error("divider width must be at least 2");
	end

	assign half = divisor[DW-1:1];
	assign sclk_q = s_q.sclk;

	// toggle once per half divisor; a stored zero parks the clock low
	always_comb begin
		s_d = s_q;
		if (half == '0) begin
			s_d.cnt = '0;
			s_d.sclk = 1'b0;
		end else if (s_q.cnt >= half - 1'b1) begin
			// >= rather than == so a smaller divisor written mid-count
			// cannot strand the counter past its end
			s_d.cnt = '0;
			s_d.sclk = ~s_q.sclk;
		end else begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ===== qcd_fifo.sv
`timescale 1ns/1ps
module qcd_fifo import qcd_pkg::*; #(
	parameter int unsigned WIDTH = DATA_W,
	parameter int unsigned DEPTH = FIFO_DEPTH,
	parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic      [CW-1:0]    count_q,
	output logic                  full_q,
	output logic                  empty_q
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// storage and pointers in one state word
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;  // entries
		logic [PW-1:0]               wptr; // next slot to fill
		logic [PW-1:0]               rptr; // oldest entry
		logic [CW-1:0]               cnt;  // valid entries
		logic                        full;
		logic                        empty;
	} qcd_fifo_st_t;

	qcd_fifo_st_t s_q;
	qcd_fifo_st_t s_d;
	logic do_push; // push accepted
	logic do_pop;  // pop accepted

	if (DEPTH < 2) begin : g_chk
		$error("fifo depth must be at least 2");
	end

	// pointer wrap that works for depths that are not powers of two
	function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
		nxt = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign do_push = push && !s_q.full;   // push into a full fifo is dropped
	assign do_pop  = pop && !s_q.empty;   // pop from an empty fifo is dropped
	assign head    = s_q.mem[s_q.rptr];
	assign count_q = s_q.cnt;
	assign full_q  = s_q.full;
	assign empty_q = s_q.empty;

	// pointer and count update; push and pop in one cycle keep the count
	always_comb begin
		s_d = s_q;
		if (do_push) begin
			s_d.mem[s_q.wptr] = push_data;
			s_d.wptr = nxt(s_q.wptr);
		end
		if (do_pop) begin
			s_d.rptr = nxt(s_q.rptr);
		end
		if (do_push && !do_pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		s_d.full  = (s_d.cnt == CW'(DEPTH));
		s_d.empty = (s_d.cnt == '0);
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.empty <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ===== qcd_top.sv
// Notes on behaviour
// - divider bit zero always stored as zero
// - divider zero stops the serial clock
// - serial clock equals block clock over divisor
// - tx threshold at or above depth ignored
// - tx empty event when level within threshold
// - master start waits for level above start
// - rx threshold above depth write ignored
// - rx full event at threshold plus one
// - tx fill level readable in three bits
`timescale 1ns/1ps
module qcd_top import qcd_pkg::*; #(
	parameter int unsigned DEPTH = FIFO_DEPTH, // entries per fifo
	parameter int unsigned DW    = DATA_W      // fifo word width
) (
	input  wire logic              MCLK,
	input  wire logic              SRST,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic      [1:0]        BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic      [31:0]       RDATA,
	output logic      [1:0]        RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY,
	input  wire logic              TX_PUSH,
	input  wire logic [DW-1:0]     TX_PUSH_DATA,
	output logic                   TX_FULL,
	input  wire logic              TX_POP,
	output logic      [DW-1:0]     TX_DATA,
	output logic                   TX_NOT_EMPTY,
	output logic                   TX_GO,
	input  wire logic              RX_PUSH,
	input  wire logic [DW-1:0]     RX_PUSH_DATA,
	output logic                   RX_FULL,
	input  wire logic              RX_POP,
	output logic      [DW-1:0]     RX_DATA,
	output logic                   RX_NOT_EMPTY,
	output logic                   SCLK_OUT,
	output logic                   IRQ
);
	localparam int unsigned CW = $clog2(DEPTH + 1); // fifo count width

	// the three-bit fields cannot address more than eight entries
	if (DEPTH < 2 || DEPTH > (1 << THR_W)) begin : g_chk
		$error("fifo depth must lie between 2 and 8");
	end

	// all block state
	typedef struct packed {
		qcd_wstate_t       wst;      // write channel phase
		logic              aw_hold;  // write address captured
		logic [ADDR_W-1:0] awaddr;
		logic              w_hold;   // write data captured
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awrdy;
		logic              wrdy;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arrdy;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [DIV_W-1:0]  div;      // divider_field, always even
		logic [THR_W-1:0]  tx_thr;   // tx_empty_threshold
		logic [THR_W-1:0]  tx_start; // tx_start_level
		logic [THR_W-1:0]  rx_thr;   // rx_full_threshold
		logic              master;   // master operation
		logic [EV_W-1:0]   sts;      // sticky events
		logic [EV_W-1:0]   mask;     // event enables
		logic              irq;
		logic              tx_go;
		logic [DW-1:0]     tx_data;  // last word handed to the shifter
		logic [DW-1:0]     rx_data;  // last word handed to software side
	} qcd_st_t;

	qcd_st_t s_q;
	qcd_st_t s_d;

	logic [DW-1:0] tx_head;   // oldest tx entry
	logic [CW-1:0] tx_cnt;    // tx entries held
	logic          tx_full;
	logic          tx_empty;
	logic [DW-1:0] rx_head;   // oldest rx entry
	logic [CW-1:0] rx_cnt;    // rx entries held
	logic          rx_full;
	logic          rx_empty;
	logic          sclk;      // divider output flop

	// byte-lane merge of a write into a register's current word
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb
	);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// a threshold write is kept only if it fits the fifo depth
	function automatic logic thr_fits(
		input logic [THR_W-1:0] val,
		input logic             allow_eq
	);
		logic [CW-1:0] v;
		v = CW'(val);
		thr_fits = allow_eq ? (v <= CW'(DEPTH)) : (v < CW'(DEPTH));
	endfunction

	// transmit fifo, filled by the data register side, drained by the shifter
	qcd_fifo #(
		.WIDTH (DW),
		.DEPTH (DEPTH),
		.CW    (CW)
	) u_txf (
		.clk       (MCLK),
		.srst      (SRST),
		.push      (TX_PUSH),
		.push_data (TX_PUSH_DATA),
		.pop       (TX_POP),
		.head      (tx_head),
		.count_q   (tx_cnt),
		.full_q    (tx_full),
		.empty_q   (tx_empty)
	);

	// receive fifo, filled by the shifter, drained by the data register side
	qcd_fifo #(
		.WIDTH (DW),
		.DEPTH (DEPTH),
		.CW    (CW)
	) u_rxf (
		.clk       (MCLK),
		.srst      (SRST),
		.push      (RX_PUSH),
		.push_data (RX_PUSH_DATA),
		.pop       (RX_POP),
		.head      (rx_head),
		.count_q   (rx_cnt),
		.full_q    (rx_full),
		.empty_q   (rx_empty)
	);

	// serial clock generator, runs whenever the divisor is non-zero
	qcd_sclk_div #(
		.DW (DIV_W)
	) u_div (
		.clk     (MCLK),
		.srst    (SRST),
		.divisor (s_q.div),
		.sclk_q  (sclk)
	);

	// outputs straight from flops
	assign AWREADY      = s_q.awrdy;
	assign WREADY       = s_q.wrdy;
	assign BVALID       = s_q.bvalid;
	assign BRESP        = s_q.bresp;
	assign ARREADY      = s_q.arrdy;
	assign RVALID       = s_q.rvalid;
	assign RDATA        = s_q.rdata;
	assign RRESP        = s_q.rresp;
	assign TX_FULL      = tx_full;
	assign TX_NOT_EMPTY = !tx_empty;
	assign RX_FULL      = rx_full;
	assign RX_NOT_EMPTY = !rx_empty;
	assign TX_DATA      = s_q.tx_data;
	assign RX_DATA      = s_q.rx_data;
	assign TX_GO        = s_q.tx_go;
	assign SCLK_OUT     = sclk;
	assign IRQ          = s_q.irq;

	// bus slave, register file, events and transmit gating
	always_comb begin
		logic [31:0]     w;   // merged write word
		logic [EV_W-1:0] clr; // status bits written with one
		logic [EV_W-1:0] ev;  // event levels this cycle
		w   = '0;
		clr = '0;
		ev  = '0;
		s_d = s_q;

		// address and data are taken independently, in either order
		if (AWVALID && s_q.awrdy) begin
			s_d.aw_hold = 1'b1;
			s_d.awaddr  = AWADDR;
		end
		if (WVALID && s_q.wrdy) begin
			s_d.w_hold = 1'b1;
			s_d.wdata  = WDATA;
			s_d.wstrb  = WSTRB;
		end

		case (s_q.wst)
			WS_COLLECT: begin
				// both halves held: commit and answer next cycle
				if (s_q.aw_hold && s_q.w_hold) begin
					s_d.aw_hold = 1'b0;
					s_d.w_hold  = 1'b0;
					s_d.bvalid  = 1'b1;
					s_d.bresp   = RESP_OKAY;
					s_d.wst     = WS_RESP;
					case (s_q.awaddr)
						OFS_DIV: begin
							w = merge(32'(s_q.div), s_q.wdata, s_q.wstrb);
							s_d.div = {w[DIV_W-1:1], 1'b0};
						end
						OFS_TXTHR: begin
							w = merge({13'h0000, s_q.tx_start, 13'h0000, s_q.tx_thr},
								s_q.wdata, s_q.wstrb);
							// the start level is free; the threshold must fit
							if (thr_fits(w[THR_LSB +: THR_W], 1'b0)) begin
								s_d.tx_thr = w[THR_LSB +: THR_W];
							end
							s_d.tx_start = w[START_LSB +: THR_W];
						end
						OFS_RXTHR: begin
							w = merge(32'(s_q.rx_thr), s_q.wdata, s_q.wstrb);
							if (thr_fits(w[THR_LSB +: THR_W], 1'b1)) begin
								s_d.rx_thr = w[THR_LSB +: THR_W];
							end
						end
						OFS_TXLVL: begin
							// read-only level: write accepted and dropped
						end
						OFS_CTRL: begin
							w = merge(32'(s_q.master), s_q.wdata, s_q.wstrb);
							s_d.master = w[CTRL_MST];
						end
						OFS_STS: begin
							w = merge('0, s_q.wdata, s_q.wstrb);
							clr = w[EV_W-1:0];
						end
						OFS_MASK: begin
							w = merge(32'(s_q.mask), s_q.wdata, s_q.wstrb);
							s_d.mask = w[EV_W-1:0];
						end
						default: begin
							s_d.bresp = RESP_SLVERR; // unmapped, nothing stored
						end
					endcase
				end
			end
			WS_RESP: begin
				if (BREADY) begin
					s_d.bvalid = 1'b0;
					s_d.wst    = WS_COLLECT;
				end
			end
			default: begin
				s_d.wst = WS_COLLECT;
			end
		endcase
		// a held half blocks its own channel until the write response is accepted
		s_d.awrdy = !s_d.aw_hold && (s_d.wst == WS_COLLECT);
		s_d.wrdy  = !s_d.w_hold && (s_d.wst == WS_COLLECT);

		// reads answer one cycle after the address is taken
		if (ARVALID && s_q.arrdy) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			case (ARADDR)
				OFS_DIV:   s_d.rdata = 32'(s_q.div);
				OFS_TXTHR: s_d.rdata = {13'h0000, s_q.tx_start, 13'h0000, s_q.tx_thr};
				OFS_RXTHR: s_d.rdata = 32'(s_q.rx_thr);
				// eight entries wrap to zero in the narrow field
				OFS_TXLVL: s_d.rdata = 32'(tx_cnt[THR_W-1:0]);
				OFS_CTRL:  s_d.rdata = 32'(s_q.master);
				OFS_STS:   s_d.rdata = 32'(s_q.sts);
				OFS_MASK:  s_d.rdata = 32'(s_q.mask);
				default: begin
					s_d.rdata = '0;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_q.rvalid && RREADY) begin
			s_d.rvalid = 1'b0;
		end
		s_d.arrdy = !s_d.rvalid;

		// event levels from the live fifo counts
		ev[EV_TXE] = (tx_cnt <= CW'(s_q.tx_thr));
		// compared as int so threshold plus one cannot wrap at any depth
		ev[EV_RXF] = (int'(rx_cnt) >= int'(s_q.rx_thr) + 1);
		// set beats clear so an event in the clearing cycle survives
		s_d.sts = (s_q.sts & ~clr) | ev;
		s_d.irq = |(s_d.sts & s_d.mask);

		// master waits for enough data; a slave is clocked by its partner
		if (s_d.master) begin
			// the start level is free, so it may be wider than a shallow count
			s_d.tx_go = (int'(tx_cnt) > int'(s_d.tx_start));
		end else begin
			s_d.tx_go = 1'b1;
		end

		// hand popped words over through a register
		if (TX_POP && !tx_empty) begin
			s_d.tx_data = tx_head;
		end
		if (RX_POP && !rx_empty) begin
			s_d.rx_data = rx_head;
		end
	end

	// state register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			s_q          <= '0;
			s_q.wst      <= WS_COLLECT;
			s_q.awrdy    <= 1'b1;
			s_q.wrdy     <= 1'b1;
			s_q.arrdy    <= 1'b1;
			s_q.div      <= DIV_RST;
			s_q.tx_thr   <= THR_RST;
			s_q.tx_start <= THR_RST;
			s_q.rx_thr   <= THR_RST;
			s_q.mask     <= MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ===== qcd_top_checker.sv
`timescale 1ns/1ps
module qcd_top_checker import qcd_pkg::*; #(
	parameter int unsigned DEPTH = FIFO_DEPTH // entries per fifo
) (
	input wire logic        MCLK,
	input wire logic        SRST,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic        RVALID,
	input wire logic        RREADY,
	input wire logic [31:0] RDATA,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic        TX_PUSH,
	input wire logic        TX_POP,
	input wire logic        TX_FULL,
	input wire logic        TX_NOT_EMPTY,
	input wire logic        RX_PUSH,
	input wire logic        RX_POP,
	input wire logic        RX_FULL,
	input wire logic        RX_NOT_EMPTY
);
	logic [3:0] tc_q; // shadow tx occupancy
	logic [3:0] rc_q; // shadow rx occupancy

	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);

	// shadow counts follow the accepted strobes, so a stuck flag shows up as a mismatch
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tc_q <= 4'h0;
			rc_q <= 4'h0;
		end else begin
			tc_q <= tc_q + 4'(TX_PUSH && !TX_FULL) - 4'(TX_POP && TX_NOT_EMPTY);
			rc_q <= rc_q + 4'(RX_PUSH && !RX_FULL) - 4'(RX_POP && RX_NOT_EMPTY);
		end
	end

	a_tx_full_lvl: assert property (TX_FULL == (tc_q == DEPTH))
		else $error("tx full flag disagrees with occupancy");
	a_tx_ne_lvl: assert property (TX_NOT_EMPTY == (tc_q != 4'h0))
		else $error("tx not-empty flag disagrees with occupancy");
	a_rx_full_lvl: assert property (RX_FULL == (rc_q == DEPTH))
		else $error("rx full flag disagrees with occupancy");
	a_rx_ne_lvl: assert property (RX_NOT_EMPTY == (rc_q != 4'h0))
		else $error("rx not-empty flag disagrees with occupancy");
	a_rd_latency: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	a_rd_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read answer dropped or changed");
	a_ar_block: assert property (RVALID |-> !ARREADY)
		else $error("address taken while answer pending");
	a_wr_hold: assert property (BVALID && !BREADY |=> BVALID)
		else $error("write response dropped");
endmodule

bind qcd_top qcd_top_checker #(.DEPTH(DEPTH)) u_qcd_top_checker (.*);

// ===== qcd_shifter_model.sv
`timescale 1ns/1ps
module qcd_shifter_model (
	input  wire logic        MCLK,
	input  wire logic        SRST,
	input  wire logic        EN,
	input  wire logic [3:0]  GAP,
	input  wire logic        TX_GO,
	input  wire logic        TX_NOT_EMPTY,
	input  wire logic [31:0] TX_DATA,
	output logic             TX_POP,
	output logic             RX_PUSH,
	output logic [31:0]      RX_PUSH_DATA
);
	logic       got_q; // pop taken last edge, word shows next cycle
	logic [3:0] w_q;   // idle cycles left between words

	// echo device: every word shifted out comes back into the rx fifo
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			TX_POP       <= 1'b0;
			RX_PUSH      <= 1'b0;
			RX_PUSH_DATA <= 32'h0;
			got_q        <= 1'b0;
			w_q          <= 4'h0;
		end else begin
			TX_POP  <= 1'b0;
			RX_PUSH <= 1'b0;
			got_q   <= TX_POP;
			// unqualified data keeps moving, so nobody can lean on a stale word
			if (got_q) begin
				RX_PUSH      <= 1'b1;
				RX_PUSH_DATA <= TX_DATA;
			end else begin
				RX_PUSH_DATA <= ~RX_PUSH_DATA;
			end
			// one word in flight at a time; GAP sets how slow the device is
			if (w_q != 4'h0) begin
				w_q <= w_q - 4'h1;
			end else if (EN && TX_GO && TX_NOT_EMPTY && !TX_POP && !got_q) begin
				TX_POP <= 1'b1;
				w_q    <= GAP;
			end
		end
	end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import qcd_pkg::*;
	localparam int DP = 4; // shallow fifo so that the refusal limits can be reached
	logic MCLK, SRST = 1'b1, PEN = 1'b0;
	logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, SCLK_OUT, TX_GO;
	logic [31:0] WDATA = 32'h0, TX_PUSH_DATA = 32'h0, RDATA, TX_DATA, RX_DATA, RX_PUSH_DATA;
	logic [3:0] WSTRB = 4'hF;
	logic [1:0] BRESP, RRESP;
	logic TX_PUSH = 1'b0, RX_POP = 1'b0, TX_FULL, TX_NOT_EMPTY, TX_POP;
	logic RX_PUSH, RX_FULL, RX_NOT_EMPTY;
	int error_cnt = 0, total_checks = 0;
	int dv[4] = '{2, 6, 10, 0}; // divisors swept, fastest first, then stopped

	qcd_top #(.DEPTH(DP)) u_qcd_top (.*);
	qcd_shifter_model u_qcd_shifter_model (.EN(PEN), .GAP(4'h3), .*);

	// free running block clock, 50 ns
	initial begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end

	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// counts gathered by the bench itself
	task cmpi(input int g, input int e);
		cmp(32'(g), 32'(e));
	endtask

	// a bound that runs out ends the run at once
	task tmo;
		error_cnt++;
		report_and_stop();
	endtask

	// address and data offered together, each dropped once taken;
	// ready may lag so that a held answer is exercised, then stays up
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0,
		input logic [3:0] s = 4'hF, input int lag = 0);
		int i;
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= (lag == 0);
		for (i = 0; i < 50; i++) begin
			@(posedge MCLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			if (BVALID && BREADY) break;
			if (i + 1 == lag) BREADY <= 1'b1;
		end
		if (i == 50) tmo();
		cmp(32'(BRESP), 32'(r));
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0,
		input int lag = 0);
		int i;
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= (lag == 0);
		for (i = 0; i < 50; i++) begin
			@(posedge MCLK);
			if (ARREADY) ARVALID <= 1'b0;
			if (RVALID && RREADY) break;
			if (i + 1 == lag) RREADY <= 1'b1;
		end
		if (i == 50) tmo();
		cmp(RDATA, e);
		cmp(32'(RRESP), 32'(r));
	endtask

	task push(input int n);
		for (int i = 0; i < n; i++) begin
			TX_PUSH <= 1'b1;
			TX_PUSH_DATA <= 32'h100 + i;
			@(posedge MCLK);
		end
		TX_PUSH <= 1'b0;
	endtask

	task rpop(input int n);
		repeat (n) begin
			RX_POP <= 1'b1;
			@(posedge MCLK);
		end
		RX_POP <= 1'b0;
	endtask

	// n samples after settling: toggles and high samples reveal rate and duty
	task sclk_chk(input int d);
		int t, h, n;
		logic p;
		t = 0;
		h = 0;
		n = (d != 0) ? 8 * d : 16;
		repeat (24) @(posedge MCLK);
		p = SCLK_OUT;
		repeat (n) begin
			@(posedge MCLK);
			t += int'(SCLK_OUT !== p);
			h += int'(SCLK_OUT === 1'b1);
			p = SCLK_OUT;
		end
		cmpi(t, (d != 0) ? 16 : 0);
		cmpi(h, 4 * d);
	endtask

	initial begin
		repeat (8) @(posedge MCLK);
		SRST <= 1'b0;
		@(posedge MCLK);
		rd(OFS_DIV, 32'h0);
		rd(OFS_TXTHR, 32'h0);
		rd(OFS_RXTHR, 32'h0);
		rd(OFS_TXLVL, 32'h0);
		cmp(32'(TX_GO), 32'h1);
		rd(8'h30, 32'h0, RESP_SLVERR);
		wr(8'h30, 32'h1, RESP_SLVERR);
		wr(OFS_DIV, 32'hFFFF);
		rd(OFS_DIV, 32'hFFFE);
		// rates from the fastest divisor up, then stopped
		foreach (dv[k]) begin
			wr(OFS_DIV, 32'(dv[k]));
			sclk_chk(dv[k]);
		end
		// answers held back by a slow ready must stand
		wr(OFS_TXTHR, 32'h0005_0003);
		rd(OFS_TXTHR, 32'h0005_0003, RESP_OKAY, 4);
		wr(OFS_TXTHR, 32'(DP), RESP_OKAY, 4'hF, 4);
		rd(OFS_TXTHR, 32'h0000_0003);
		wr(OFS_RXTHR, 32'(DP));
		rd(OFS_RXTHR, 32'(DP));
		wr(OFS_RXTHR, 32'(DP + 1));
		rd(OFS_RXTHR, 32'(DP));
		// tx event at the threshold boundary
		wr(OFS_MASK, 32'h1);
		push(3);
		wr(OFS_STS, 32'h3);
		rd(OFS_STS, 32'h1);
		cmp(32'(IRQ), 32'h1);
		push(1);
		wr(OFS_STS, 32'h3);
		rd(OFS_STS, 32'h0);
		cmp(32'(IRQ), 32'h0);
		rd(OFS_TXLVL, 32'(DP));
		push(1);
		rd(OFS_TXLVL, 32'(DP));
		cmp(32'(TX_FULL), 32'h1);
		// master start waits for more than the start level
		wr(OFS_CTRL, 32'h1);
		wr(OFS_TXTHR, 32'h0004_0003);
		repeat (2) @(posedge MCLK);
		cmp(32'(TX_GO), 32'h0);
		wr(OFS_TXTHR, 32'h0003_0003);
		repeat (2) @(posedge MCLK);
		cmp(32'(TX_GO), 32'h1);
		// echo all words into rx, then drain across the rx boundary
		wr(OFS_CTRL, 32'h0);
		wr(OFS_RXTHR, 32'h1);
		PEN <= 1'b1;
		repeat (60) @(posedge MCLK);
		rd(OFS_TXLVL, 32'h0);
		// fifo order: 100, 101, 102, then 100 again from the single push
		cmp(TX_DATA, 32'h0000_0100);
		cmp(32'(RX_FULL), 32'h1);
		rpop(2);
		@(posedge MCLK);
		cmp(RX_DATA, 32'h0000_0101);
		wr(OFS_STS, 32'h3);
		rd(OFS_STS, 32'h3);
		rpop(1);
		@(posedge MCLK);
		cmp(RX_DATA, 32'h0000_0102);
		wr(OFS_STS, 32'h3);
		rd(OFS_STS, 32'h1);
		wr(OFS_MASK, 32'h2);
		repeat (2) @(posedge MCLK);
		cmp(32'(IRQ), 32'h0);
		wr(OFS_MASK, 32'h1);
		repeat (2) @(posedge MCLK);
		cmp(32'(IRQ), 32'h1);
		// low byte only: threshold changes, start level keeps its value
		wr(OFS_TXTHR, 32'h0006_0002, RESP_OKAY, 4'h1);
		rd(OFS_TXTHR, 32'h0003_0002);
		report_and_stop();
	end
endmodule
